/* common/fu_pkg.sv */
// Purpose: Shared types, encodings and latencies of the functional units
// Assumes: One processor clock, operands arrive from external register files
// Notes:   Latencies are fixed per unit; changing one reshapes a pipeline
package fu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int unsigned AW   = 24;  // Address word
  localparam int unsigned SW   = 64;  // Scalar word and vector element
  localparam int unsigned DSW  = 128; // Two concatenated scalar words
  localparam int unsigned VLW  = 7;   // Vector length, 0..64
  localparam int unsigned EIW  = 6;   // Element index
  localparam int unsigned CNW  = 7;   // Count results and shift counts
  localparam int unsigned DW   = 3;   // Destination register number
  localparam int unsigned NVU  = 4;   // Vector units
  localparam int unsigned NRC  = 5;   // Scalar and address result paths

  ////////////////////////////////////////////////////////////////////////////
  // Unit latencies in clock periods
  localparam int unsigned LAT_AADD   = 2;
  localparam int unsigned LAT_AMUL   = 4;
  localparam int unsigned LAT_SADD   = 3;
  localparam int unsigned LAT_SSHIFT = 2;
  localparam int unsigned LAT_SLOG   = 1;
  localparam int unsigned LAT_SCNT   = 3;
  localparam int unsigned SH_GAP     = LAT_SADD - LAT_SSHIFT;
  localparam int unsigned VU_LAT [NVU] = '{3, 2, 2, 6};

  ////////////////////////////////////////////////////////////////////////////
  // Unit selection
  typedef enum logic [3:0] {
    U_AADD   = 4'h0,
    U_AMUL   = 4'h1,
    U_SADD   = 4'h2,
    U_SSHIFT = 4'h3,
    U_SLOG   = 4'h4,
    U_SCNT   = 4'h5,
    U_VADD   = 4'h6,
    U_VLOG   = 4'h7,
    U_VPOP   = 4'h8
  } fu_unit_t;

  // Operation codes, one family per unit kind
  localparam logic [2:0] OP_ADD  = 3'h0;
  localparam logic [2:0] OP_SUB  = 3'h1;
  localparam logic [2:0] OP_OR   = 3'h0;
  localparam logic [2:0] OP_AND  = 3'h1;
  localparam logic [2:0] OP_XNOR = 3'h2;
  localparam logic [2:0] OP_XOR  = 3'h3;
  localparam logic [2:0] OP_MRG  = 3'h4;
  localparam logic [2:0] OP_SHL  = 3'h0;
  localparam logic [2:0] OP_SHR  = 3'h1;
  localparam logic [2:0] OP_DSHL = 3'h2;
  localparam logic [2:0] OP_DSHR = 3'h3;
  localparam logic [2:0] OP_POP  = 3'h0;
  localparam logic [2:0] OP_PAR  = 3'h1;
  localparam logic [2:0] OP_LZC  = 3'h2;

  // Vector unit slots and scalar result paths
  localparam int unsigned VU_ADD  = 0;
  localparam int unsigned VU_LOGF = 1;
  localparam int unsigned VU_LOGS = 2;
  localparam int unsigned VU_POP  = 3;
  localparam int unsigned RC_AADD = 0;
  localparam int unsigned RC_AMUL = 1;
  localparam int unsigned RC_SASH = 2;
  localparam int unsigned RC_SLOG = 3;
  localparam int unsigned RC_SCNT = 4;

  // Vector unit sequencing
  typedef enum logic [1:0] {
    VS_IDLE  = 2'b00,
    VS_FEED  = 2'b01,
    VS_DRAIN = 2'b10
  } vu_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    fu_unit_t        unit;
    logic [2:0]      op;
    logic [DW-1:0]   dest;
    logic [AW-1:0]   a_op1;    // Also the shift count
    logic [AW-1:0]   a_op2;
    logic [SW-1:0]   s_op1;    // Also the scalar operand of vector ops
    logic [SW-1:0]   s_op2;
    logic [SW-1:0]   s_mask;   // Scalar merge mask
    logic            use_scalar;
  } issue_req_t;

  typedef struct packed {
    logic            vld;
    logic [DW-1:0]   dest;
    logic [SW-1:0]   data;     // Address results sit in the low bits
  } res_t;

  typedef struct packed {
    logic            vld;
    logic            last;
    logic [DW-1:0]   dest;
    logic [EIW-1:0]  idx;
    logic [SW-1:0]   data;
  } vres_t;

  typedef struct packed {
    logic [SW-1:0]   a;
    logic [SW-1:0]   b;
  } velem_t;

  ////////////////////////////////////////////////////////////////////////////
  // Count helpers
  function automatic logic [CNW-1:0] pop64(input logic [SW-1:0] v);
    logic [CNW-1:0] c;
    c = '0;
    for (int k = 0; k < SW; k++) begin
      c = c + CNW'(v[k]);
    end
    return c;
  endfunction : pop64

  // Zeros ahead of the first one from the top; all zero gives the width
  function automatic logic [CNW-1:0] lzc64(input logic [SW-1:0] v);
    logic [CNW-1:0] c;
    logic           seen;
    c    = '0;
    seen = 1'b0;
    for (int k = SW - 1; k >= 0; k--) begin
      if (v[k]) begin
        seen = 1'b1;
      end else if (!seen) begin
        c = c + CNW'(1);
      end
    end
    return c;
  endfunction : lzc64

endpackage : fu_pkg

/* src/fu_core.sv */
// Purpose: Address, scalar and vector integer functional units with issue
// Assumes: Register files answer element reads in the same cycle
// Notes:   Floating-point units live outside; their busy lines gate issue
`timescale 1ns/1ns
module fu_core (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Issue requests
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire fu_pkg::issue_req_t  req,
  // Vector control registers, sampled when a vector operation issues
  input  wire logic [fu_pkg::VLW-1:0] vector_length_reg,
  input  wire logic [fu_pkg::SW-1:0]  vector_mask_reg,
  // Neighbouring units and selection
  input  wire logic                sec_vlog_en,
  input  wire logic                fp_mul_busy,
  input  wire logic                recip_busy,
  // Scalar and address results, one per output path
  output fu_pkg::res_t             s_res [fu_pkg::NRC],
  // Vector element streams
  output logic [fu_pkg::EIW-1:0]   v_rd_idx [fu_pkg::NVU],
  input  wire fu_pkg::velem_t      v_elem [fu_pkg::NVU],
  output fu_pkg::vres_t            v_res [fu_pkg::NVU],
  output logic [fu_pkg::NVU-1:0]   vu_reserved
);

  localparam int unsigned RW = $bits(fu_pkg::res_t);
  localparam int unsigned VW = $bits(fu_pkg::vres_t);

  fu_pkg::issue_req_t     bq;
  logic                   bv, go, hold, is_vec, vsel_ok;
  logic [1:0]             vsel;
  logic [fu_pkg::NVU-1:0] vstart;
  logic [fu_pkg::SH_GAP-1:0] add_hist_r, add_hist_nxt;
  fu_pkg::res_t           in_aadd, in_amul, in_sadd, in_ssh, in_slog, in_scnt;
  fu_pkg::res_t           o_sadd, o_ssh;
  logic [fu_pkg::DSW-1:0] dbl, dsh;
  logic [2*fu_pkg::AW-1:0] prod;
  logic [fu_pkg::CNW-1:0] shc, cnt_v;

  ////////////////////////////////////////////////////////////////////////////
  // Request buffer; holds below back up into req_ready
  req_buf2 #(
    .W ($bits(fu_pkg::issue_req_t))
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req),
    .out_valid (bv),
    .out_ready (go),
    .out_data  (bq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Issue decision: a reserved or conflicted target holds the head request
  always_comb begin
    is_vec  = (bq.unit == fu_pkg::U_VADD) || (bq.unit == fu_pkg::U_VLOG) ||
              (bq.unit == fu_pkg::U_VPOP);
    vsel    = 2'(fu_pkg::VU_ADD);
    vsel_ok = 1'b0;
    unique case (bq.unit)
      fu_pkg::U_VADD: begin
        vsel_ok = !vu_reserved[fu_pkg::VU_ADD];
      end
      fu_pkg::U_VPOP: begin
        vsel    = 2'(fu_pkg::VU_POP);
        vsel_ok = !vu_reserved[fu_pkg::VU_POP] && !recip_busy;
      end
      fu_pkg::U_VLOG: begin
        // Second unit first, unless busy or its paths are lent out
        if (sec_vlog_en && !vu_reserved[fu_pkg::VU_LOGS] &&
            !fp_mul_busy) begin
          vsel    = 2'(fu_pkg::VU_LOGS);
          vsel_ok = 1'b1;
        end else if (!vu_reserved[fu_pkg::VU_LOGF]) begin
          vsel    = 2'(fu_pkg::VU_LOGF);
          vsel_ok = 1'b1;
        end
      end
      default: begin
        vsel_ok = 1'b0;
      end
    endcase
    // Shift whose result would meet an earlier add on the shared path
    hold = (is_vec && !vsel_ok) ||
           ((bq.unit == fu_pkg::U_SSHIFT) &&
            add_hist_r[fu_pkg::SH_GAP-1]);
    go   = bv && !hold;
    for (int k = 0; k < fu_pkg::NVU; k++) begin
      vstart[k] = go && is_vec && (vsel == 2'(k));
    end
    add_hist_nxt = fu_pkg::SH_GAP'({add_hist_r,
                                    go && (bq.unit == fu_pkg::U_SADD)});
  end

  // History of scalar add issues for the shared output path
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      add_hist_r <= '0;
    end else begin
      add_hist_r <= add_hist_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scalar and address operations on the head request
  always_comb begin
    in_aadd      = '0;
    in_amul      = '0;
    in_sadd      = '0;
    in_ssh       = '0;
    in_slog      = '0;
    in_scnt      = '0;
    in_aadd.vld  = go && (bq.unit == fu_pkg::U_AADD);
    in_amul.vld  = go && (bq.unit == fu_pkg::U_AMUL);
    in_sadd.vld  = go && (bq.unit == fu_pkg::U_SADD);
    in_ssh.vld   = go && (bq.unit == fu_pkg::U_SSHIFT);
    in_slog.vld  = go && (bq.unit == fu_pkg::U_SLOG);
    in_scnt.vld  = go && (bq.unit == fu_pkg::U_SCNT);
    in_aadd.dest = bq.dest;
    in_amul.dest = bq.dest;
    in_sadd.dest = bq.dest;
    in_ssh.dest  = bq.dest;
    in_slog.dest = bq.dest;
    in_scnt.dest = bq.dest;
    // Wrapping sum, carry out dropped, no overflow flag
    in_aadd.data[fu_pkg::AW-1:0] = (bq.op == fu_pkg::OP_SUB) ?
      bq.a_op1 - bq.a_op2 : bq.a_op1 + bq.a_op2;
    // Signed product keeps negative index steps; low half, unrounded
    prod = 48'($signed(bq.a_op1) * $signed(bq.a_op2));
    in_amul.data[fu_pkg::AW-1:0] = prod[fu_pkg::AW-1:0];
    in_sadd.data = (bq.op == fu_pkg::OP_SUB) ?
      bq.s_op1 - bq.s_op2 : bq.s_op1 + bq.s_op2;
    // End-off shifts with zero fill; count comes from an address operand
    shc = bq.a_op1[fu_pkg::CNW-1:0];
    dbl = {bq.s_op1, bq.s_op2};
    dsh = '0;
    unique case (bq.op)
      fu_pkg::OP_SHL:  dsh = {bq.s_op1, {fu_pkg::SW{1'b0}}} << shc;
      fu_pkg::OP_SHR:  dsh = {bq.s_op1, {fu_pkg::SW{1'b0}}} >> shc;
      fu_pkg::OP_DSHL: dsh = dbl << shc;
      fu_pkg::OP_DSHR: dsh = (dbl >> shc) << fu_pkg::SW;
      default:         dsh = '0;
    endcase
    in_ssh.data = dsh[fu_pkg::DSW-1:fu_pkg::SW];
    unique case (bq.op)
      fu_pkg::OP_OR:   in_slog.data = bq.s_op1 | bq.s_op2;
      fu_pkg::OP_AND:  in_slog.data = bq.s_op1 & bq.s_op2;
      fu_pkg::OP_XNOR: in_slog.data = ~(bq.s_op1 ^ bq.s_op2);
      fu_pkg::OP_XOR:  in_slog.data = bq.s_op1 ^ bq.s_op2;
      fu_pkg::OP_MRG:  in_slog.data = (bq.s_op1 & bq.s_mask) |
                                      (bq.s_op2 & ~bq.s_mask);
      default:         in_slog.data = '0;
    endcase
    // Count results return to an address register
    unique case (bq.op)
      fu_pkg::OP_POP: cnt_v = fu_pkg::pop64(bq.s_op1);
      fu_pkg::OP_PAR: cnt_v = {{(fu_pkg::CNW-1){1'b0}}, ^bq.s_op1};
      fu_pkg::OP_LZC: cnt_v = fu_pkg::lzc64(bq.s_op1);
      default:        cnt_v = '0;
    endcase
    in_scnt.data[fu_pkg::CNW-1:0] = cnt_v;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-latency pipelines, one operand set per cycle each
  fu_pipe #(.W(RW), .LAT(fu_pkg::LAT_AADD)) u_aadd (
    .clk_sys (clk_sys), .rst (rst), .din (in_aadd),
    .dout    (s_res[fu_pkg::RC_AADD])
  );
  fu_pipe #(.W(RW), .LAT(fu_pkg::LAT_AMUL)) u_amul (
    .clk_sys (clk_sys), .rst (rst), .din (in_amul),
    .dout    (s_res[fu_pkg::RC_AMUL])
  );
  fu_pipe #(.W(RW), .LAT(fu_pkg::LAT_SADD)) u_sadd (
    .clk_sys (clk_sys), .rst (rst), .din (in_sadd), .dout (o_sadd)
  );
  fu_pipe #(.W(RW), .LAT(fu_pkg::LAT_SSHIFT)) u_ssh (
    .clk_sys (clk_sys), .rst (rst), .din (in_ssh), .dout (o_ssh)
  );
  fu_pipe #(.W(RW), .LAT(fu_pkg::LAT_SLOG)) u_slog (
    .clk_sys (clk_sys), .rst (rst), .din (in_slog),
    .dout    (s_res[fu_pkg::RC_SLOG])
  );
  fu_pipe #(.W(RW), .LAT(fu_pkg::LAT_SCNT)) u_scnt (
    .clk_sys (clk_sys), .rst (rst), .din (in_scnt),
    .dout    (s_res[fu_pkg::RC_SCNT])
  );

  // Shared add/shift output; the issue hold keeps these apart
  assign s_res[fu_pkg::RC_SASH] = o_ssh.vld ? o_ssh : o_sadd;

  ////////////////////////////////////////////////////////////////////////////
  // Vector units: reservation, element sequencing and pipeline per slot
  for (genvar i = 0; i < fu_pkg::NVU; i++) begin : g_vu
    fu_pkg::vu_state_t         st_r, st_nxt;
    logic [fu_pkg::VLW-1:0]    cnt_r, cnt_nxt, len_r, len_nxt;
    logic [2:0]                op_r, op_nxt;
    logic [fu_pkg::DW-1:0]     dst_r, dst_nxt;
    logic [fu_pkg::SW-1:0]     msk_r, msk_nxt, scl_r, scl_nxt;
    logic                      usc_r, usc_nxt, mbit;
    logic [fu_pkg::SW-1:0]     ea, eb, ev;
    fu_pkg::vres_t             pin, pout;

    // Element operation for this slot's unit kind
    always_comb begin
      ea   = v_elem[i].a;
      eb   = usc_r ? scl_r : v_elem[i].b;
      // Top mask bit belongs to element zero
      mbit = msk_r[fu_pkg::SW-1-int'(cnt_r[fu_pkg::EIW-1:0])];
      ev   = '0;
      if (i == fu_pkg::VU_ADD) begin
        ev = (op_r == fu_pkg::OP_SUB) ? ea - eb : ea + eb;
      end else if (i == fu_pkg::VU_POP) begin
        ev = {{(fu_pkg::SW-fu_pkg::CNW){1'b0}}, fu_pkg::pop64(ea)};
        if (op_r == fu_pkg::OP_PAR) begin
          ev = {{(fu_pkg::SW-1){1'b0}}, ev[0]};
        end
      end else begin
        unique case (op_r)
          fu_pkg::OP_OR:   ev = ea | eb;
          fu_pkg::OP_AND:  ev = ea & eb;
          fu_pkg::OP_XNOR: ev = ~(ea ^ eb);
          fu_pkg::OP_XOR:  ev = ea ^ eb;
          fu_pkg::OP_MRG:  ev = mbit ? ea : eb;
          default:         ev = '0;
        endcase
      end
    end

    // Sequencer: feed one element per cycle, then wait for the last result
    always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      len_nxt = len_r;
      op_nxt  = op_r;
      dst_nxt = dst_r;
      msk_nxt = msk_r;
      scl_nxt = scl_r;
      usc_nxt = usc_r;
      unique case (st_r)
        fu_pkg::VS_IDLE: begin
          if (vstart[i] && (vector_length_reg != '0)) begin
            st_nxt  = fu_pkg::VS_FEED;
            cnt_nxt = '0;
            len_nxt = vector_length_reg;
            op_nxt  = bq.op;
            dst_nxt = bq.dest;
            msk_nxt = vector_mask_reg;
            scl_nxt = bq.s_op1;
            usc_nxt = bq.use_scalar;
          end
        end
        fu_pkg::VS_FEED: begin
          cnt_nxt = cnt_r + fu_pkg::VLW'(1);
          if (cnt_r == len_r - fu_pkg::VLW'(1)) begin
            st_nxt = fu_pkg::VS_DRAIN;
          end
        end
        fu_pkg::VS_DRAIN: begin
          if (pout.vld && pout.last) begin
            st_nxt = fu_pkg::VS_IDLE;
          end
        end
        default: begin
          st_nxt = fu_pkg::VS_IDLE;
        end
      endcase
      pin      = '0;
      pin.vld  = (st_r == fu_pkg::VS_FEED);
      pin.last = (cnt_r == len_r - fu_pkg::VLW'(1));
      pin.dest = dst_r;
      pin.idx  = cnt_r[fu_pkg::EIW-1:0];
      pin.data = ev;
    end

    // Slot state
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        st_r  <= fu_pkg::VS_IDLE;
        cnt_r <= '0;
        len_r <= '0;
        op_r  <= '0;
        dst_r <= '0;
        msk_r <= '0;
        scl_r <= '0;
        usc_r <= 1'b0;
      end else begin
        st_r  <= st_nxt;
        cnt_r <= cnt_nxt;
        len_r <= len_nxt;
        op_r  <= op_nxt;
        dst_r <= dst_nxt;
        msk_r <= msk_nxt;
        scl_r <= scl_nxt;
        usc_r <= usc_nxt;
      end
    end

    // Constant unit time per slot
    fu_pipe #(.W(VW), .LAT(fu_pkg::VU_LAT[i])) u_vpipe (
      .clk_sys (clk_sys), .rst (rst), .din (pin), .dout (pout)
    );

    assign v_res[i]       = pout;
    assign v_rd_idx[i]    = cnt_r[fu_pkg::EIW-1:0];
    assign vu_reserved[i] = (st_r != fu_pkg::VS_IDLE);
  end : g_vu

endmodule : fu_core

/* src/fu_pipe.sv */
// Purpose: Fixed-latency, fully segmented delay line for one unit
// Assumes: LAT of at least one clock period
// Notes:   Never stalls; a new word may enter every cycle
`timescale 1ns/1ns
module fu_pipe #(
  parameter int unsigned W   = 8,
  parameter int unsigned LAT = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Stream
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] st_r   [LAT];
  logic [W-1:0] st_nxt [LAT];

  ////////////////////////////////////////////////////////////////////////////
  // Each stage takes the one before it, so every cycle holds its own word
  always_comb begin
    st_nxt[0] = din;
    for (int k = 1; k < LAT; k++) begin
      st_nxt[k] = st_r[k-1];
    end
  end

  // Stage registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < LAT; k++) begin
        st_r[k] <= '0;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r[LAT-1];

endmodule : fu_pipe

/* src/req_buf2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Drain side may hold ready low for any time
// Notes:   Two entries keep a full-rate source at full rate; a one-cycle hold still stalls it one cycle
`timescale 1ns/1ns
module req_buf2 #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic         wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // Honest full and empty from the occupancy count
  always_comb begin
    in_ready  = (cnt_r != 2'h2);
    out_valid = (cnt_r != 2'h0);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    mem_nxt   = mem_r;
    wp_nxt    = wp_r;
    rp_nxt    = rp_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  // Storage and pointers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign out_data = mem_r[rp_r];

endmodule : req_buf2

/* tb/fu_core_properties.sv */
// Purpose: Timing relations at the ports of the unit core
// Assumes: Latencies from the shared package
// Notes:   Bound to every core instance
`timescale 1ns/1ns
module fu_core_properties (
  // Clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // Observed ports
  input wire logic                      recip_busy,
  input wire fu_pkg::res_t              s_res [fu_pkg::NRC],
  input wire logic [fu_pkg::EIW-1:0]    v_rd_idx [fu_pkg::NVU],
  input wire fu_pkg::vres_t             v_res [fu_pkg::NVU],
  input wire logic [fu_pkg::NVU-1:0]    vu_reserved
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Address sum and count results stay inside their field
  a_addr_high_zero: assert property (s_res[0].vld |->
    s_res[0].data[63:24] == '0) else $error("address sum too wide");
  a_count_range: assert property (s_res[4].vld |->
    s_res[4].data <= 64'h40) else $error("count out of range");
  // Element k leaves exactly the unit time after it was read
  a_vadd_lat: assert property (v_res[0].vld |->
    v_res[0].idx == $past(v_rd_idx[0], 3)) else $error("vadd latency");
  a_vlog_lat: assert property (v_res[1].vld |->
    v_res[1].idx == $past(v_rd_idx[1], 2)) else $error("vlog latency");
  a_vpop_lat: assert property (v_res[3].vld |->
    v_res[3].idx == $past(v_rd_idx[3], 6)) else $error("vpop latency");
  // Reservation spans the whole stream and ends after the last
  a_held_reserved: assert property (v_res[0].vld |->
    vu_reserved[0]) else $error("result without reservation");
  a_last_release: assert property (v_res[3].vld && v_res[3].last
    |=> !vu_reserved[3]) else $error("reservation kept");
  a_feed_start: assert property ($rose(vu_reserved[2]) |->
    v_rd_idx[2] == '0) else $error("feed not from element 0");
  a_pop_blocked: assert property ($rose(vu_reserved[3]) |->
    !$past(recip_busy)) else $error("pop issued on shared logic");
endmodule : fu_core_properties
bind fu_core fu_core_properties chk_u (.clk_sys(clk_sys), .rst(rst),
  .recip_busy(recip_busy), .s_res(s_res), .v_rd_idx(v_rd_idx),
  .v_res(v_res), .vu_reserved(vu_reserved));

/* tb/testbench.sv */
// Purpose: Self-checking bench of the unit core
// Assumes: Expected values rebuilt from operands here
// Notes:   Random scalar burst, then vector and buffer corners
`timescale 1ns/1ns
module testbench;
  logic                   clk_sys, rst, req_valid, req_ready;
  logic                   sec_vlog_en, fp_mul_busy, recip_busy, vsc [4];
  fu_pkg::issue_req_t     req, r;
  logic [6:0]             vector_length_reg;
  logic [63:0]            vector_mask_reg, vs [4];
  fu_pkg::res_t           s_res [5];
  logic [5:0]             v_rd_idx [4];
  fu_pkg::velem_t         v_elem [4];
  fu_pkg::vres_t          v_res [4];
  logic [3:0]             vu_reserved;
  logic [63:0]            sq [5][$];
  logic [2:0]             vop [4];
  int                     error_cnt, check_count, nel, tot, ec [4];

  fu_core dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .vector_length_reg(vector_length_reg),
    .vector_mask_reg(vector_mask_reg), .sec_vlog_en(sec_vlog_en),
    .fp_mul_busy(fp_mul_busy), .recip_busy(recip_busy), .s_res(s_res),
    .v_rd_idx(v_rd_idx), .v_elem(v_elem), .v_res(v_res),
    .vu_reserved(vu_reserved));
  vreg_model reg_u (.v_rd_idx(v_rd_idx), .v_elem(v_elem));

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  function automatic logic [63:0] lg(logic [2:0] o, logic [63:0] a, b, m);
    case (o)
      fu_pkg::OP_OR:   return a | b;
      fu_pkg::OP_AND:  return a & b;
      fu_pkg::OP_XNOR: return a ~^ b;
      fu_pkg::OP_XOR:  return a ^ b;
      default:         return (a & m) | (b & ~m);
    endcase
  endfunction : lg

  // All zero gives the full width
  function automatic logic [63:0] lz(logic [63:0] v);
    lz = 64'h40;
    for (int j = 0; j < 64; j++) if (v[j]) lz = 63 - j;
  endfunction : lz

  function automatic logic [63:0] sx(fu_pkg::issue_req_t q);
    logic [127:0] d;
    logic [23:0]  t;
    logic [6:0]   n;
    n = q.a_op1[6:0];
    d = {q.s_op1, q.s_op2};
    t = q.op[0] ? q.a_op1 - q.a_op2 : q.a_op1 + q.a_op2;
    case (q.unit)
      fu_pkg::U_AADD: return {40'h0, t};
      fu_pkg::U_AMUL: begin
        t = $signed(q.a_op1) * $signed(q.a_op2);
        return {40'h0, t};
      end
      fu_pkg::U_SADD: return q.op[0] ? q.s_op1 - q.s_op2 : q.s_op1 + q.s_op2;
      fu_pkg::U_SSHIFT: begin
        if (q.op[1]) d = q.op[0] ? d >> n : d << n;
        else d = {q.op[0] ? q.s_op1 >> n : q.s_op1 << n, 64'h0};
        return q.op == fu_pkg::OP_DSHR ? d[63:0] : d[127:64];
      end
      fu_pkg::U_SLOG: return lg(q.op, q.s_op1, q.s_op2, q.s_mask);
      default: begin
        n = $countones(q.s_op1);
        if (q.op == fu_pkg::OP_LZC) return lz(q.s_op1);
        return q.op[0] ? 64'(n[0]) : 64'(n);
      end
    endcase
  endfunction : sx

  function automatic logic [63:0] vx(int k, logic [5:0] i);
    logic [63:0] a, b;
    logic [6:0]  c;
    a = {8{2'(k), i}};
    b = vsc[k] ? vs[k] : {a[31:0], ~a[63:32]};
    c = $countones(a);
    if (k == 0) return vop[0][0] ? a - b : a + b;
    if (k == 3) return vop[3][0] ? 64'(c[0]) : 64'(c);
    return lg(vop[k], a, b, {64{vector_mask_reg[63 - i]}});
  endfunction : vx

  function automatic fu_pkg::issue_req_t rnd();
    fu_pkg::issue_req_t q;
    int u;
    u = $urandom_range(5);
    q = '0;
    q.unit = fu_pkg::fu_unit_t'(u);
    q.dest = 3'(u - (u > 2)); // Result path number
    q.op = 3'($urandom_range(u == 4 ? 4 : u == 3 ? 3 : u == 5 ? 2 : 1));
    q.a_op1 = 24'($urandom);
    q.a_op2 = 24'($urandom);
    q.s_op1 = $urandom_range(4) ? {$urandom, $urandom} : 64'h0;
    q.s_op2 = {$urandom, $urandom};
    q.s_mask = {$urandom, $urandom};
    return q;
  endfunction : rnd

  // Offer and hold until taken; valid stays up for back-to-back sends
  task automatic send(fu_pkg::issue_req_t q);
    int n;
    n = 0;
    req <= q;
    req_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100) chk("take", 0, 1);
    if (q.unit < fu_pkg::U_VADD) sq[q.unit - (q.unit > 2)].push_back(sx(q));
  endtask : send

  task automatic idle(int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic vgo(fu_pkg::fu_unit_t u, int o, len, s, logic [3:0] rv);
    int n;
    r = '0;
    r.unit = u;
    r.op = 3'(o);
    r.dest = 3'(s);
    r.use_scalar = 1'($urandom_range(1));
    r.s_op1 = {$urandom, $urandom};
    vop[s] = r.op;
    vsc[s] = r.use_scalar;
    vs[s] = r.s_op1;
    tot += len;
    vector_length_reg <= 7'(len);
    @(posedge clk_sys);
    send(r);
    idle(3);
    chk("rsv", vu_reserved, rv);
    n = 0;
    while (vu_reserved !== 4'h0 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    chk("drain", n < 200, 1);
  endtask : vgo

  // Scoreboard on every result path, in issue order
  always @(posedge clk_sys) begin
    for (int p = 0; p < 5; p++) if (s_res[p].vld === 1'b1) begin
      if (sq[p].size() == 0) chk("extra", 1, 0);
      else chk("s_res", s_res[p].data, sq[p].pop_front());
      chk("s_dst", s_res[p].dest, p);
    end
    for (int k = 0; k < 4; k++) if (v_res[k].vld === 1'b1) begin
      chk("v_res", v_res[k].data, vx(k, 6'(ec[k])));
      chk("v_idx", v_res[k].idx, ec[k]);
      chk("v_dst", v_res[k].dest, k);
      ec[k]++;
      nel++;
      if (v_res[k].last === 1'b1) ec[k] = 0;
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Far beyond the expected several hundred cycles
  initial begin
    #2000000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hc5b1_3bb6));
    {rst, sec_vlog_en, req_valid, fp_mul_busy, recip_busy} = 5'h18;
    req = '0;
    vector_length_reg = 7'h8;
    vector_mask_reg = {$urandom, $urandom};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Random burst: every scalar and address unit and op, add then shift collisions included
    repeat (300) send(rnd());
    idle(10);
    for (int o = 0; o < 2; o++) vgo(fu_pkg::U_VADD, o, o ? 1 : 64, 0, 4'h1);
    for (int o = 0; o < 5; o++) vgo(fu_pkg::U_VLOG, o, 5, 2, 4'h4);
    fp_mul_busy <= 1'b1;
    vgo(fu_pkg::U_VLOG, 3, 5, 1, 4'h2);
    fp_mul_busy <= 1'b0;
    sec_vlog_en <= 1'b0;
    vgo(fu_pkg::U_VLOG, 4, 5, 1, 4'h2);
    for (int o = 0; o < 2; o++) vgo(fu_pkg::U_VPOP, o, 64, 3, 4'h8);
    vgo(fu_pkg::U_VADD, 0, 0, 0, 4'h0);
    // Held pop fills the buffer until it refuses
    recip_busy <= 1'b1;
    vop[3] = fu_pkg::OP_POP;
    r = '0;
    r.unit = fu_pkg::U_VPOP;
    r.dest = 3'h3;
    vector_length_reg <= 7'h3;
    tot += 3;
    @(posedge clk_sys);
    send(r);
    r.unit = fu_pkg::U_SLOG;
    r.s_op1 = {$urandom, $urandom};
    send(r);
    idle(1);
    chk("full", req_ready, 0);
    chk("held", vu_reserved, 0);
    recip_busy <= 1'b0;
    idle(80);
    for (int p = 0; p < 5; p++) chk("left", sq[p].size(), 0);
    chk("elems", nel, tot);
    end_of_test();
  end
endmodule : testbench

/* tb/vreg_model.sv */
// Purpose: Vector register file answering element reads
// Assumes: Reads answer in the same cycle
// Notes:   Values change with every index, so a stale read shows
`timescale 1ns/1ns
module vreg_model (
  // Element reads
  input wire logic [fu_pkg::EIW-1:0] v_rd_idx [fu_pkg::NVU],
  output fu_pkg::velem_t             v_elem [fu_pkg::NVU]
);
  // Pattern of slot and index
  always_comb begin
    for (int k = 0; k < fu_pkg::NVU; k++) begin
      v_elem[k].a = {8{2'(k), v_rd_idx[k]}};
      v_elem[k].b = {v_elem[k].a[31:0], ~v_elem[k].a[63:32]};
    end
  end
endmodule : vreg_model
